// ---- design/rts_sequencer.sv ----
`timescale 1ns/10ps
module rts_sequencer
	import rts_pkg::*;
#(
	parameter int PLL_LOCK_CYCLES = RTS_PLL_CYCLES,
	parameter int CNT_W = 18
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic por_pulse,
	input wire logic brownout_det,
	input wire logic internal_slow_osc,
	input wire logic crystal_input_pin,
	input wire logic external_reset_pin_n,
	input wire rts_osc_mode_t osc_mode,
	input wire logic powerup_delay_disable_cfg,
	input wire logic stack_fault_reset_cfg,
	input wire logic [1:0] brownout_mode_cfg,
	input wire rts_pwr_state_t pwr_state,
	input wire logic pm_exit_req,
	input wire rts_events_t core_events,
	input wire logic [RTS_PC_W-1:0] pc,
	input wire logic high_prio_irq_global_en,
	input wire logic low_prio_irq_global_en,
	input wire logic flag_wr_en,
	input wire rts_flags_t flag_wr_data,
	input wire logic sbe_wr_en,
	input wire logic sbe_wr_data,
	input wire logic scratch_wr_en,
	input wire logic [RTS_SCRATCH_W-1:0] scratch_wr_data,
	output logic core_reset,
	output logic clock_stable,
	output logic restart_strobe,
	output logic [RTS_PC_W-1:0] restart_pc,
	output rts_flags_t flags,
	output logic sw_brownout_enable,
	output logic [RTS_SCRATCH_W-1:0] scratch
);

	if (PLL_LOCK_CYCLES < 1 || PLL_LOCK_CYCLES > 2 ** CNT_W - 1 || RTS_POWERUP_DELAY_TIMER_TICKS > 2 ** CNT_W - 1) begin : g_chk
		$error("rts_sequencer: delay counts do not fit CNT_W");
	end

	typedef enum logic [2:0] {
		seq_por,
		seq_powerup_delay_timer,
		seq_ost,
		seq_pll,
		seq_run
	} rts_seq_t;

	typedef enum logic [3:0] {
		cause_none,
		cause_por,
		cause_bor,
		cause_stack_ovf,
		cause_stack_unf,
		cause_unf_err,
		cause_wdt_reset,
		cause_wdt_wake,
		cause_pin_run,
		cause_pin_idle,
		cause_pin_full,
		cause_reset_instr,
		cause_irq_wake
	} rts_cause_t;

	function automatic logic [CNT_W-1:0] rts_cnt(input int value);
		rts_cnt = value[CNT_W-1:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Input sampling and edge detection.

	rts_seq_t state;
	rts_seq_t next_state;
	logic wake_seq;
	logic next_wake_seq;
	logic slow_q;
	logic xtal_q;
	logic pin_q;
	logic por_q;
	logic bor_q;
	logic sbe;

	// Brown-out detection is gated by its configuration before it can hold the chip.
	wire logic bor_active = brownout_det && ((brownout_mode_cfg == RTS_BOR_ON) ||
		(brownout_mode_cfg == RTS_BOR_NO_SLEEP && pwr_state != pwr_sleep) ||
		(brownout_mode_cfg == RTS_BOR_SW && sw_brownout_enable));

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			slow_q <= 1'b0;
			xtal_q <= 1'b0;
			pin_q <= 1'b0;
			por_q <= 1'b1;
			bor_q <= 1'b0;
		end else if (clk_en) begin
			slow_q <= internal_slow_osc;
			xtal_q <= crystal_input_pin;
			pin_q <= external_reset_pin_n;
			por_q <= por_pulse;
			bor_q <= bor_active;
		end
	end

	wire logic slow_edge = internal_slow_osc & ~slow_q;
	wire logic xtal_edge = crystal_input_pin & ~xtal_q;
	wire logic pin_fall = pin_q & ~external_reset_pin_n;
	wire logic por_rise = por_pulse & ~por_q;
	wire logic xtal_mode = (osc_mode == crystal_lowpwr_mode) || (osc_mode == crystal_mid_mode) ||
		(osc_mode == crystal_fast_mode) || (osc_mode == crystal_fast_mult_mode);
	wire logic pll_mode = (osc_mode == crystal_fast_mult_mode);
	wire logic pm_sleepy = (pwr_state == pwr_idle) || (pwr_state == pwr_sleep);
	wire logic bor_rise = bor_active & ~bor_q;
	wire logic por_hold = por_pulse | bor_active;

	////////////////////////////////////////////////////////////////////////////////
	// Time-out sequence.

	logic [CNT_W-1:0] cnt_value;
	logic cnt_done;
	logic cnt_load;
	logic [CNT_W-1:0] cnt_load_value;
	logic cnt_tick;

	always_comb begin
		next_state = state;
		next_wake_seq = wake_seq;
		case (state)
			seq_por: begin
				next_wake_seq = 1'b0;
				if (!por_hold) begin
					if (!powerup_delay_disable_cfg) begin
						next_state = seq_powerup_delay_timer; // [R4] [R7]
					end else if (xtal_mode) begin
						next_state = seq_ost; // [R2]
					end else begin
						next_state = seq_run; // [R5]
					end
				end
			end
			seq_powerup_delay_timer: begin
				if (cnt_done) begin
					next_state = xtal_mode ? seq_ost : seq_run; // [R4] [R5]
				end
			end
			seq_ost: begin
				if (cnt_done) begin
					next_state = pll_mode ? seq_pll : seq_run; // [R1] [R3]
				end
			end
			seq_pll: begin
				if (cnt_done) begin
					next_state = seq_run; // [R3]
				end
			end
			seq_run: begin
				if (pm_exit_req && xtal_mode) begin
					next_state = seq_ost; // [R2]
					next_wake_seq = 1'b1;
				end
			end
			default: begin
				next_state = seq_por;
			end
		endcase
		// A brown-out anywhere sends the sequence back and re-arms the delays.
		if (por_hold) begin
			next_state = seq_por; // [R22]
			next_wake_seq = 1'b0;
		end
	end

	assign cnt_load = (next_state != state) && (next_state != seq_run) && (next_state != seq_por);
	assign cnt_load_value = (next_state == seq_powerup_delay_timer) ? rts_cnt(RTS_POWERUP_DELAY_TIMER_TICKS) : // [R21]
		(next_state == seq_ost) ? rts_cnt(RTS_OST_EDGES) : rts_cnt(PLL_LOCK_CYCLES); // [R1] [R3]
	assign cnt_tick = (state == seq_powerup_delay_timer) ? slow_edge : (state == seq_ost) ? xtal_edge : 1'b1; // [R21]

	rts_down_counter #(
		.WIDTH(CNT_W)
	) u_delay (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(clk_en),
		.load(cnt_load),
		.load_value(cnt_load_value),
		.tick(cnt_tick),
		.count(cnt_value),
		.done(cnt_done)
	);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= seq_por;
			wake_seq <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			wake_seq <= next_wake_seq;
		end
	end

	// The pin is not looked at by the delays, so a long hold lets them all expire first.
	assign core_reset = ((state != seq_run) && !wake_seq) || !external_reset_pin_n; // [R6] [R23]
	assign clock_stable = (state == seq_run);

	////////////////////////////////////////////////////////////////////////////////
	// Reset and wake cause, flags and restart address.

	wire rts_cause_t cause =
		(por_rise) ? cause_por :
		(bor_rise) ? cause_bor :
		(state != seq_run) ? cause_none :
		(core_events.stack_overflow && stack_fault_reset_cfg) ? cause_stack_ovf :
		(core_events.stack_underflow) ? (stack_fault_reset_cfg ? cause_stack_unf : cause_unf_err) :
		(core_events.wdt_timeout) ? (pm_sleepy ? cause_wdt_wake : cause_wdt_reset) :
		(pin_fall) ? ((pwr_state == pwr_full) ? cause_pin_full :
			(pwr_state == pwr_run) ? cause_pin_run : cause_pin_idle) :
		(core_events.reset_instr) ? cause_reset_instr :
		(core_events.irq_wake && pm_sleepy) ? cause_irq_wake : cause_none;

	wire logic [RTS_PC_W-1:0] pc_next = RTS_PC_W'(pc + RTS_PC_STEP);
	wire logic [RTS_PC_W-1:0] irq_target = high_prio_irq_global_en ? RTS_VEC_HIGH :
		low_prio_irq_global_en ? RTS_VEC_LOW : pc_next; // [R19]
	wire logic is_restart = (cause != cause_none) && (cause != cause_unf_err) && (cause != cause_por);
	wire logic is_reset = is_restart && (cause != cause_wdt_wake) && (cause != cause_irq_wake);

	rts_flags_t next_flags;
	logic [RTS_PC_W-1:0] next_restart_pc;

	// Software writes are applied first so a hardware cause in the same cycle wins.
	always_comb begin
		next_flags = flag_wr_en ? flag_wr_data : flags;
		next_restart_pc = RTS_RESET_VEC;
		case (cause)
			cause_por: begin
				next_flags = RTS_FLAGS_POR; // [R10]
			end
			cause_bor: begin
				next_flags.soft_reset_cmd_flag = 1'b1; // [R11]
				next_flags.watchdog_expired_flag = 1'b1;
				next_flags.power_down_flag = 1'b1;
				next_flags.brownout_flag = 1'b0;
			end
			cause_stack_ovf: begin
				next_flags.stack_overflow_flag = 1'b1; // [R16]
			end
			cause_stack_unf, cause_unf_err: begin
				next_flags.stack_underflow_flag = 1'b1; // [R17]
			end
			cause_wdt_reset: begin
				next_flags.watchdog_expired_flag = 1'b0; // [R14]
			end
			cause_wdt_wake: begin
				next_flags.watchdog_expired_flag = 1'b0; // [R18]
				next_flags.power_down_flag = 1'b0;
				next_restart_pc = pc_next;
			end
			cause_pin_run: begin
				next_flags.watchdog_expired_flag = 1'b1; // [R12]
			end
			cause_pin_idle: begin
				next_flags.watchdog_expired_flag = 1'b1; // [R13]
				next_flags.power_down_flag = 1'b0;
			end
			cause_pin_full: begin
				next_restart_pc = RTS_RESET_VEC; // [R15]
			end
			cause_reset_instr: begin
				next_flags.soft_reset_cmd_flag = 1'b0; // [R11]
			end
			cause_irq_wake: begin
				next_flags.power_down_flag = 1'b0; // [R19]
				next_restart_pc = irq_target;
			end
			default: begin
				next_restart_pc = RTS_RESET_VEC;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			flags <= RTS_FLAGS_POR; // [R10]
			restart_strobe <= 1'b0;
			restart_pc <= RTS_RESET_VEC;
		end else if (clk_en) begin
			flags <= next_flags;
			restart_strobe <= is_restart;
			restart_pc <= (is_restart || cause == cause_por) ? next_restart_pc : restart_pc; // [R10]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Software brown-out enable and retained scratch register.

	// A power-on or a software write sets it; other resets keep it solely in software brown-out mode.
	wire logic sbe_keep = (brownout_mode_cfg == RTS_BOR_SW) && sbe;
	wire logic next_sbe = (cause == cause_por) ? RTS_SBE_RST :
		((is_reset || cause == cause_bor) && !sbe_keep) ? 1'b0 :
		sbe_wr_en ? sbe_wr_data : sbe; // [R20]

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sbe <= RTS_SBE_RST; // [R20]
		end else if (clk_en) begin
			sbe <= next_sbe;
		end
	end

	assign sw_brownout_enable = sbe && (brownout_mode_cfg == RTS_BOR_SW); // [R20]

	// Only rst clears scratch; a power-on pulse, wakes and resets all leave its value.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			scratch <= RTS_SCRATCH_RST; // [R8]
		end else if (clk_en && scratch_wr_en) begin
			scratch <= scratch_wr_data; // [R8] [R9]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	powerup_delay_timer_first_a: assert property (@(posedge ref_clk) disable iff (rst) // [R4]
		(state == seq_ost && $past(state) == seq_por) |-> $past(powerup_delay_disable_cfg))
		else $error("crystal count started before the power-up delay");

	ost_mode_a: assert property (@(posedge ref_clk) disable iff (rst) // [R2]
		(state == seq_ost) |-> xtal_mode)
		else $error("crystal count ran in a non-crystal mode");

	pll_order_a: assert property (@(posedge ref_clk) disable iff (rst) // [R3]
		(state == seq_pll && $past(state) != seq_pll) |-> ($past(state) == seq_ost && pll_mode))
		else $error("PLL delay did not follow the crystal count");

	powerup_delay_timer_load_a: assert property (@(posedge ref_clk) disable iff (rst) // [R21]
		(state == seq_powerup_delay_timer && $past(state) == seq_por) |-> (cnt_value == rts_cnt(RTS_POWERUP_DELAY_TIMER_TICKS)))
		else $error("power-up delay loaded with wrong count");

	release_gate_a: assert property (@(posedge ref_clk) disable iff (rst) // [R23]
		(state == seq_run && $past(state) != seq_run) |-> ($past(cnt_done) || $past(state) == seq_por))
		else $error("reset released before the delays expired");

	por_flags_a: assert property (@(posedge ref_clk) disable iff (rst) // [R10]
		(clk_en && por_rise) |=> (flags == RTS_FLAGS_POR && restart_pc == RTS_RESET_VEC && restart_strobe == 1'b0))
		else $error("power-on flags or vector wrong");

	wdt_wake_a: assert property (@(posedge ref_clk) disable iff (rst) // [R18]
		(clk_en && cause == cause_wdt_wake) |=> (restart_strobe && restart_pc == $past(pc_next) &&
		!flags.watchdog_expired_flag && !flags.power_down_flag))
		else $error("watchdog wake handled wrongly");

	underflow_a: assert property (@(posedge ref_clk) disable iff (rst) // [R17]
		(clk_en && (cause == cause_unf_err)) |=> (flags.stack_underflow_flag && !restart_strobe))
		else $error("underflow error not recorded or restarted");

	bor_restart_a: assert property (@(posedge ref_clk) disable iff (rst) // [R22]
		(clk_en && bor_active) |=> (state == seq_por))
		else $error("brown-out did not restart the sequence");

	full_seq_c: cover property (@(posedge ref_clk) disable iff (rst)
		state == seq_pll ##1 state == seq_run);
	irq_wake_c: cover property (@(posedge ref_clk) disable iff (rst) cause == cause_irq_wake);
	pin_idle_c: cover property (@(posedge ref_clk) disable iff (rst) cause == cause_pin_idle);

endmodule

// ---- design/rts_pkg.sv ----
// What this block does
// R1: Hold reset 1024 crystal edges after delay.
// R2: Crystal count only crystal modes, POR/wake.
// R3: PLL mode adds 2 ms lock delay.
// R4: Power-up delay first, then crystal count.
// R5: Other modes: only power-up delay, if enabled.
// R6: Delays count from power-on, ignore pin.
// R7: Power-up delay inserted when disable bit clear.
// R8: Undefined registers keep value except power-on.
// R9: Watchdog wake keeps registers unchanged.
// R10: Power-on: vector zero, fixed flag pattern.
// R11: Reset instruction and brown-out flag updates.
// R12: Pin in run mode sets watchdog flag.
// R13: Pin in idle/sleep: watchdog set, power-down clear.
// R14: Watchdog reset clears watchdog flag only.
// R15: Pin in full power keeps all flags.
// R16: Stack overflow reset sets overflow flag.
// R17: Underflow always flagged, resets when configured.
// R18: Watchdog wake: PC plus 2, clear two flags.
// R19: Interrupt wake: clear power-down, PC+2 or vector.
// R20: Software brown-out enable reset behaviour.
// R21: Power-up delay is 2048 slow oscillator ticks.
// R22: Brown-out during delay restarts the delay.
// R23: Release only when delays done, pin high.
package rts_pkg;

	localparam int RTS_PC_W = 21;
	localparam int RTS_SCRATCH_W = 8;
	localparam int RTS_CLK_MHZ = 125;
	localparam int RTS_POWERUP_DELAY_TIMER_BITS = 11;
	localparam int RTS_POWERUP_DELAY_TIMER_TICKS = 2 ** RTS_POWERUP_DELAY_TIMER_BITS;
	localparam int RTS_OST_EDGES = 1024;
	localparam int RTS_PLL_LOCK_US = 2000;
	localparam int RTS_PLL_CYCLES = RTS_PLL_LOCK_US * RTS_CLK_MHZ;

	localparam logic [RTS_PC_W-1:0] RTS_RESET_VEC = 21'h0_0000;
	localparam logic [RTS_PC_W-1:0] RTS_VEC_HIGH = 21'h0_0008;
	localparam logic [RTS_PC_W-1:0] RTS_VEC_LOW = 21'h0_0018;
	localparam logic [RTS_PC_W-1:0] RTS_PC_STEP = 21'h0_0002;
	localparam logic [RTS_SCRATCH_W-1:0] RTS_SCRATCH_RST = 8'h00;

	localparam logic [1:0] RTS_BOR_OFF = 2'h0;
	localparam logic [1:0] RTS_BOR_SW = 2'h1;
	localparam logic [1:0] RTS_BOR_NO_SLEEP = 2'h2;
	localparam logic [1:0] RTS_BOR_ON = 2'h3;
	localparam logic RTS_SBE_RST = 1'h1;

	typedef enum logic [3:0] {
		crystal_lowpwr_mode,
		crystal_mid_mode,
		crystal_fast_mode,
		crystal_fast_mult_mode,
		resistor_cap_osc_mode,
		resistor_cap_gpio_mode,
		external_clock_mode,
		external_clock_gpio_mode,
		internal_osc_mode_a,
		internal_osc_mode_b
	} rts_osc_mode_t;

	typedef enum logic [1:0] {
		pwr_full,
		pwr_run,
		pwr_idle,
		pwr_sleep
	} rts_pwr_state_t;

	typedef struct packed {
		logic soft_reset_cmd_flag;
		logic watchdog_expired_flag;
		logic power_down_flag;
		logic power_on_flag;
		logic brownout_flag;
		logic stack_overflow_flag;
		logic stack_underflow_flag;
	} rts_flags_t;

	localparam rts_flags_t RTS_FLAGS_POR = 7'h70;

	typedef struct packed {
		logic reset_instr;
		logic wdt_timeout;
		logic stack_overflow;
		logic stack_underflow;
		logic irq_wake;
	} rts_events_t;

endpackage

// ---- design/rts_down_counter.sv ----
`timescale 1ns/10ps
module rts_down_counter #(
	parameter int WIDTH = 18
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic load,
	input wire logic [WIDTH-1:0] load_value,
	input wire logic tick,
	output logic [WIDTH-1:0] count,
	output logic done
);

	if (WIDTH < 2) begin : g_chk
		$error("rts_down_counter: WIDTH must be at least 2");
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (clk_en) begin
			if (load) begin
				count <= load_value;
			end else if (tick && count != '0) begin
				count <= count - 1'b1;
			end
		end
	end

	assign done = (count == '0);

endmodule

// ---- tb/rts_far_side.sv ----
`timescale 1ns/10ps
module rts_far_side #(
	parameter int XTAL_HALF_NS = 20
) (
	input wire logic hold_low,
	output logic crystal_input_pin,
	output logic external_reset_pin_n
);
	////////////////////////////////////////////////////////////
	// The crystal free-runs on its own odd-offset time base, so its edges never meet ref_clk edges.
	initial begin
		crystal_input_pin = 1'b0;
		#3;
		forever begin
			#(XTAL_HALF_NS);
			crystal_input_pin = ~crystal_input_pin;
		end
	end
	////////////////////////////////////////////////////////////
	// The pin has a pull-up, so it reads high unless the driver holds it low.
	assign external_reset_pin_n = hold_low ? 1'b0 : 1'b1;
endmodule

// ---- tb/rts_sequencer_test.sv ----
`timescale 1ns/10ps
module rts_sequencer_test
	import rts_pkg::*;
;
	localparam int PLL_N = 20;
	localparam int XTAL_CYC = 5;
	localparam int SLOW_CYC = 2;
	logic ref_clk, rst, por_pulse, brownout_det, internal_slow_osc, hold_low, crystal_input_pin;
	logic external_reset_pin_n, powerup_delay_disable_cfg, stack_fault_reset_cfg, pm_exit_req;
	logic high_prio_irq_global_en, low_prio_irq_global_en, flag_wr_en, sbe_wr_en, sbe_wr_data;
	logic scratch_wr_en, core_reset, clock_stable, restart_strobe, sw_brownout_enable;
	logic [1:0] brownout_mode_cfg;
	logic [RTS_PC_W-1:0] pc, restart_pc;
	logic [RTS_SCRATCH_W-1:0] scratch_wr_data, scratch, sv;
	rts_osc_mode_t osc_mode;
	rts_pwr_state_t pwr_state;
	rts_events_t core_events;
	rts_flags_t flag_wr_data, flags, f0;
	int err_total, check_count, n;

	rts_sequencer #(.PLL_LOCK_CYCLES(PLL_N), .CNT_W(18)) rts_sequencer_inst (.ref_clk, .rst, .clk_en(1'b1),
		.por_pulse, .brownout_det, .internal_slow_osc, .crystal_input_pin, .external_reset_pin_n, .osc_mode,
		.powerup_delay_disable_cfg, .stack_fault_reset_cfg, .brownout_mode_cfg, .pwr_state, .pm_exit_req,
		.core_events, .pc, .high_prio_irq_global_en, .low_prio_irq_global_en, .flag_wr_en, .flag_wr_data,
		.sbe_wr_en, .sbe_wr_data, .scratch_wr_en, .scratch_wr_data, .core_reset, .clock_stable,
		.restart_strobe, .restart_pc, .flags, .sw_brownout_enable, .scratch);
	rts_far_side rts_far_side_inst (.hold_low, .crystal_input_pin, .external_reset_pin_n);

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// The slow oscillator is sped up so one power-up delay fits the run.
	always @(posedge ref_clk) begin
		#1;
		internal_slow_osc = ~internal_slow_osc;
	end
	////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask
	task automatic chk_near(int got, int t, int lo, int hi);
		check_count++;
		if (got < t + lo || got > t + hi) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, t);
			err_total++;
		end
	endtask
	function automatic int exp_len(rts_osc_mode_t m, logic dis);
		exp_len = dis ? 0 : RTS_POWERUP_DELAY_TIMER_TICKS * SLOW_CYC;
		if (m <= crystal_fast_mult_mode) exp_len += 1024 * XTAL_CYC;
		if (m == crystal_fast_mult_mode) exp_len += PLL_N;
	endfunction
	// Kinds: 0 reset instruction, 1 watchdog, 2 overflow, 3 underflow, 4 interrupt, 5 pin, 6 brown-out.
	function automatic rts_flags_t exp_flags(int k, rts_pwr_state_t p, rts_flags_t f);
		logic slp;
		slp = (p == pwr_idle) || (p == pwr_sleep);
		exp_flags = f;
		if (k == 0 || k == 6) exp_flags.soft_reset_cmd_flag = (k == 6);
		if (k == 1) exp_flags.watchdog_expired_flag = 1'b0;
		if ((k == 5 && p != pwr_full) || k == 6) exp_flags.watchdog_expired_flag = 1'b1;
		if ((k == 1 || k == 5) && slp || k == 4) exp_flags.power_down_flag = 1'b0;
		if (k == 6) exp_flags.power_down_flag = 1'b1;
		if (k == 6) exp_flags.brownout_flag = 1'b0;
		if (k == 2) exp_flags.stack_overflow_flag = 1'b1;
		if (k == 3) exp_flags.stack_underflow_flag = 1'b1;
	endfunction
	function automatic logic [RTS_PC_W-1:0] exp_pc(int k, rts_pwr_state_t p, logic [RTS_PC_W-1:0] cur);
		exp_pc = 21'h0_0000;
		if (k == 1 && (p == pwr_idle || p == pwr_sleep)) exp_pc = cur + 21'h0_0002;
		if (k == 4) exp_pc = high_prio_irq_global_en ? 21'h0_0008 :
			low_prio_irq_global_en ? 21'h0_0018 : cur + 21'h0_0002;
	endfunction
	////////////////////////////////////////////////////////////
	task automatic wait_run();
		for (int i = 0; i < 20000 && !(clock_stable === 1'b1 && core_reset === 1'b0); i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (clock_stable !== 1'b1 || core_reset !== 1'b0) begin
			err_total++;
			end_of_test();
		end
	endtask
	task automatic sw_write(int w, logic [7:0] v);
		flag_wr_data = v[6:0];
		sbe_wr_data = v[0];
		scratch_wr_data = v;
		{flag_wr_en, sbe_wr_en, scratch_wr_en} = {w == 0, w == 1, w == 2};
		@(posedge ref_clk);
		#1;
		{flag_wr_en, sbe_wr_en, scratch_wr_en} = 3'h0;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic power_up(rts_osc_mode_t m, logic dis, int por_len, int bor_at, int pin_len);
		int t;
		rst = 1'b1;
		osc_mode = m;
		powerup_delay_disable_cfg = dis;
		por_pulse = (por_len > 0);
		hold_low = (pin_len > 0);
		repeat (5) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		t = (por_len > bor_at ? por_len : bor_at) + exp_len(m, dis);
		n = 0;
		while (core_reset !== 1'b0 && n < t + pin_len + 200) begin
			@(posedge ref_clk);
			#1;
			n++;
			if (n == por_len) por_pulse = 1'b0;
			if (n == pin_len) hold_low = 1'b0;
			brownout_det = (bor_at > 0 && n >= bor_at && n < bor_at + 3);
		end
		if (pin_len > t) chk_near(n, pin_len, 0, 3);
		else chk_near(n, t, -12, 12);
		chk(32'(flags), 32'h70);
		chk(32'(restart_pc), 32'h0);
		wait_run();
	endtask
	task automatic run_event(int k);
		rts_flags_t ef;
		logic [RTS_PC_W-1:0] ep;
		ef = exp_flags(k, pwr_state, flags);
		ep = exp_pc(k, pwr_state, pc);
		if (k < 5) core_events = rts_events_t'(5'h10 >> k);
		else hold_low = 1'b1;
		@(posedge ref_clk);
		#1;
		core_events = '0;
		for (int i = 0; i < 4 && restart_strobe !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		chk(32'(restart_strobe), 32'h1);
		chk(32'(restart_pc), 32'(ep));
		chk(32'(flags), 32'(ef));
		hold_low = 1'b0;
		@(posedge ref_clk);
		#1;
		chk(32'(restart_strobe), 32'h0);
		wait_run();
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		{rst, por_pulse, brownout_det, internal_slow_osc, hold_low, pm_exit_req} = 6'h20;
		{high_prio_irq_global_en, low_prio_irq_global_en, flag_wr_en, sbe_wr_en, sbe_wr_data} = 5'h00;
		{scratch_wr_en, powerup_delay_disable_cfg, stack_fault_reset_cfg} = 3'h3;
		{flag_wr_data, scratch_wr_data, core_events, pc} = '0;
		brownout_mode_cfg = 2'h3;
		osc_mode = resistor_cap_osc_mode;
		pwr_state = pwr_full;
		err_total = 0;
		check_count = 0;
		void'($urandom(81));
		for (int i = 0; i < 10; i++) power_up(rts_osc_mode_t'(i), 1'b1, 0, 0, 0);
		power_up(crystal_fast_mult_mode, 1'b0, 0, 0, 0);
		power_up(external_clock_mode, 1'b0, 40, 0, 0);
		power_up(resistor_cap_osc_mode, 1'b0, 0, 1500, 0);
		power_up(crystal_mid_mode, 1'b0, 0, 0, 12000);
		// Faster restarts keep the event sweep short; timing was covered above.
		power_up(resistor_cap_osc_mode, 1'b1, 0, 0, 0);
		sv = 8'($urandom);
		sw_write(2, sv);
		for (int r = 0; r < 6; r++) begin
			for (int p = 0; p < 4; p++) begin
				pwr_state = rts_pwr_state_t'(p);
				{high_prio_irq_global_en, low_prio_irq_global_en} = 2'($urandom);
				pc = 21'($urandom);
				for (int k = 0; k < 6; k++) begin
					sw_write(0, 8'($urandom));
					if (k != 4 || p >= 2) run_event(k);
				end
			end
		end
		chk(32'(scratch), 32'(sv));
		pwr_state = pwr_full;
		stack_fault_reset_cfg = 1'b0;
		f0 = flags;
		f0.stack_underflow_flag = 1'b1;
		core_events = rts_events_t'(5'h03);
		@(posedge ref_clk);
		#1;
		core_events = '0;
		chk(32'(restart_strobe), 32'h0);
		@(posedge ref_clk);
		#1;
		chk(32'(flags), 32'(f0));
		sw_write(0, 8'($urandom));
		f0 = exp_flags(6, pwr_state, flags);
		brownout_det = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		brownout_det = 1'b0;
		wait_run();
		chk(32'(flags), 32'(f0));
		brownout_mode_cfg = 2'h1;
		power_up(resistor_cap_osc_mode, 1'b1, 0, 0, 0);
		chk(32'(sw_brownout_enable), 32'h1);
		run_event(0);
		chk(32'(sw_brownout_enable), 32'h1);
		sw_write(1, 8'h00);
		run_event(0);
		chk(32'(sw_brownout_enable), 32'h0);
		sw_write(1, 8'h01);
		brownout_mode_cfg = 2'h2;
		run_event(0);
		brownout_mode_cfg = 2'h1;
		#1;
		chk(32'(sw_brownout_enable), 32'h0);
		power_up(crystal_lowpwr_mode, 1'b1, 0, 0, 0);
		pwr_state = pwr_run;
		pm_exit_req = 1'b1;
		@(posedge ref_clk);
		#1;
		pm_exit_req = 1'b0;
		@(posedge ref_clk);
		#1;
		chk(32'(clock_stable), 32'h0);
		chk(32'(core_reset), 32'h0);
		n = 0;
		while (clock_stable !== 1'b1 && n < 7000) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk_near(n, 1024 * XTAL_CYC, -12, 12);
		chk(32'(core_reset), 32'h0);
		// A power-on pulse in mid-run must bring back the fixed flags and the zero vector.
		pwr_state = pwr_sleep;
		run_event(1);
		por_pulse = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		por_pulse = 1'b0;
		chk(32'(flags), 32'h70);
		chk(32'(restart_pc), 32'h0);
		wait_run();
		end_of_test();
	end
endmodule
